/* hdl/t1xf_framer.sv */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module t1xf_framer
  import t1xf_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire  logic              clk,
  input  wire  logic              reset_n,
  input  wire  logic [ADDR_W-1:0] avs_address,
  input  wire  logic              avs_read,
  input  wire  logic              avs_write,
  input  wire  logic [3:0]        avs_byteenable,
  input  wire  logic [31:0]       avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire  logic              line_tick,
  input  wire  logic              fractional_mode,
  input  wire  t1xf_chan_t        chan_ctrl,
  output logic [4:0]              chan_index_q,
  output logic                    line_bit_q,
  output logic                    line_valid_q,
  output logic                    egress_channel_clock_q
);

  if (ADDR_W < 10) begin : g_addr_check
    $error("ADDR_W too small to reach the register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one wait cycle, then answer
  logic [7:0] basic_cfg_q;
  logic [7:0] alarm_ctrl_q;
  logic [7:0] inband_ctrl_q;
  logic [7:0] inband_pat_q;
  logic [7:0] frame_q;
  logic       bus_hit;
  logic [7:0] bus_idx;
  logic [7:0] status_byte;

  assign bus_hit = (avs_read | avs_write) & avs_waitrequest;
  assign bus_idx = (avs_address[1:0] == 2'h0) ? avs_address[9:2] : 8'hff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !bus_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      basic_cfg_q   <= T1XF_RST_CFG;
      alarm_ctrl_q  <= T1XF_RST_ALM;
      inband_ctrl_q <= T1XF_RST_IBC;
    end else if (bus_hit && avs_write && avs_byteenable[0]) begin
      case (bus_idx)
        T1XF_IDX_BASIC_CFG:   basic_cfg_q   <= avs_writedata[7:0];
        T1XF_IDX_ALARM_CTRL:  alarm_ctrl_q  <= avs_writedata[7:0] & T1XF_ALM_MASK;
        T1XF_IDX_INBAND_CTRL: inband_ctrl_q <= avs_writedata[7:0] & T1XF_IBC_MASK;
        default: ;
      endcase
    end
  end

  // No reset: the pattern survives a device reset
  always_ff @(posedge clk) begin
    if (bus_hit && avs_write && avs_byteenable[0] && bus_idx == T1XF_IDX_INBAND_PAT) begin
      inband_pat_q <= avs_writedata[7:0];
    end
  end

  assign status_byte = {inband_ctrl_q[T1XF_IBC_EN_BIT], 2'h0, frame_q[4:0]};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (bus_hit && avs_read) begin
      case (bus_idx)
        T1XF_IDX_BASIC_CFG:   avs_readdata <= {24'h00_0000, basic_cfg_q};
        T1XF_IDX_ALARM_CTRL:  avs_readdata <= {24'h00_0000, alarm_ctrl_q};
        T1XF_IDX_INBAND_CTRL: avs_readdata <= {24'h00_0000, inband_ctrl_q};
        T1XF_IDX_INBAND_PAT:  avs_readdata <= {24'h00_0000, inband_pat_q};
        T1XF_IDX_STATUS:      avs_readdata <= {24'h00_0000, status_byte};
        default:              avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame position
  logic       trunk;
  logic       esf;
  logic       yellow;
  logic       ib_en;
  logic       ib_uf;
  logic [7:0] bit_pos_q;
  logic [4:0] sf_frames;
  logic       fbit_slot;
  logic       chan_start;
  logic       sig_frame;

  assign trunk      = basic_cfg_q[T1XF_CFG_TRUNK_BIT];
  assign esf        = basic_cfg_q[T1XF_CFG_ESF_BIT];
  assign yellow     = alarm_ctrl_q[T1XF_ALM_YEL_BIT];
  assign ib_en      = inband_ctrl_q[T1XF_IBC_EN_BIT];
  assign ib_uf      = inband_ctrl_q[T1XF_IBC_UF_BIT];
  assign sf_frames  = esf ? T1XF_ESF_FRAMES : T1XF_SF_FRAMES;
  assign fbit_slot  = (bit_pos_q == 8'h00);
  assign chan_start = !fbit_slot && (bit_pos_q[2:0] == 3'h1);
  assign sig_frame  = (frame_q[4:0] % 5'h06) == 5'h05;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bit_pos_q <= 8'h00;
      frame_q   <= 8'h00;
    end else if (line_tick) begin
      if (bit_pos_q == T1XF_FRAME_BITS - 8'h01) begin
        bit_pos_q <= 8'h00;
        frame_q   <= (frame_q[4:0] >= sf_frames - 5'h01) ? 8'h00 : frame_q + 8'h01;
      end else begin
        bit_pos_q <= bit_pos_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chan_index_q <= 5'h00;
    end else begin
      chan_index_q <= fbit_slot ? 5'h00 : 5'((bit_pos_q - 8'h01) >> 3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel byte shaping
  logic [7:0] after_idle;
  logic [7:0] after_sig;
  logic [7:0] after_yel;
  logic [1:0] zcs_eff;
  logic       do_idle;
  logic       do_sig;
  logic [7:0] shaped;

  assign do_idle    = trunk | chan_ctrl.channel_idle_enable;
  assign do_sig     = (trunk | chan_ctrl.channel_signaling_condition)
                      & chan_ctrl.signaling_control_upper & sig_frame;
  assign after_idle = do_idle ? chan_ctrl.idle_code : chan_ctrl.payload;
  assign after_sig  = {after_idle[7:1], do_sig ? chan_ctrl.signaling_bit : after_idle[0]};
  assign after_yel  = (yellow && !esf) ? (after_sig & 8'hbf) : after_sig;
  assign zcs_eff    = basic_cfg_q[1:0] | chan_ctrl.zero_suppress_select;

  always_comb begin
    shaped = after_yel;
    if (after_yel == 8'h00) begin
      case (zcs_eff)
        T1XF_ZCS_BIT7: shaped = 8'h02;
        T1XF_ZCS_BIT8: shaped = sig_frame ? 8'h02 : 8'h01;
        default:       shaped = after_yel;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inband code generator
  logic [2:0] ib_idx_q;
  logic [2:0] ib_last;
  logic       ib_bit;
  logic       ib_use;

  assign ib_last = T1XF_CODE_LEN_MIN + {1'b0, inband_ctrl_q[1:0]} - 3'h1;
  assign ib_bit  = inband_pat_q[3'h7 - ib_idx_q];
  // Framing slots only draw code bits when unframed, so framed mode holds the code over the framing bit
  assign ib_use  = line_tick && ib_en && (!fbit_slot || ib_uf);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ib_idx_q <= 3'h0;
    end else if (!ib_en) begin
      ib_idx_q <= 3'h0;
    end else if (ib_use) begin
      ib_idx_q <= (ib_idx_q >= ib_last) ? 3'h0 : ib_idx_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framing bits, CRC-6 and data link
  logic [5:0] crc_q;
  logic [5:0] crc_hold_q;
  logic [4:0] yel_idx_q;
  logic       fbit;
  logic       fdl_bit;
  logic       out_bit;
  logic [7:0] shift_q;
  logic       crc_in;
  logic [2:0] esf_sub;

  assign esf_sub = 3'(frame_q[4:2]);
  assign fdl_bit = yellow ? T1XF_YEL_BOC[5'h10 - yel_idx_q] : 1'b1;

  always_comb begin
    if (!esf) begin
      fbit = T1XF_SF_FBITS[4'hb - frame_q[3:0]];
    end else begin
      case (frame_q[1:0])
        2'h1:    fbit = crc_hold_q[3'h5 - esf_sub];
        2'h3:    fbit = T1XF_ESF_FAS[3'h5 - esf_sub];
        default: fbit = fdl_bit;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      yel_idx_q <= 5'h00;
    end else if (!yellow) begin
      yel_idx_q <= 5'h00;
    end else if (line_tick && fbit_slot && esf && !frame_q[0] && !ib_uf) begin
      yel_idx_q <= (yel_idx_q == T1XF_YEL_BOC_LEN - 5'h01) ? 5'h00 : yel_idx_q + 5'h01;
    end
  end

  always_comb begin
    if (fbit_slot) begin
      if (ib_uf) begin
        out_bit = ib_en ? ib_bit : 1'b1;
      end else begin
        out_bit = fbit;
      end
    end else if (ib_en) begin
      out_bit = ib_bit;
    end else begin
      out_bit = chan_start ? shaped[7] : shift_q[7];
    end
  end

  // CRC covers the emitted stream with framing positions taken as one
  assign crc_in = fbit_slot ? 1'b1 : out_bit;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      crc_q      <= 6'h00;
      crc_hold_q <= 6'h00;
    end else if (line_tick) begin
      if (bit_pos_q == T1XF_FRAME_BITS - 8'h01 && frame_q[4:0] == sf_frames - 5'h01) begin
        crc_hold_q <= {crc_q[4:0], 1'b0} ^ ((crc_q[5] ^ crc_in) ? T1XF_CRC_POLY : 6'h00);
        crc_q      <= 6'h00;
      end else begin
        crc_q <= {crc_q[4:0], 1'b0} ^ ((crc_q[5] ^ crc_in) ? T1XF_CRC_POLY : 6'h00);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      shift_q <= 8'h00;
    end else if (line_tick && !fbit_slot) begin
      shift_q <= chan_start ? {shaped[6:0], 1'b0} : {shift_q[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line outputs
  logic idle_seen_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      idle_seen_q <= 1'b0;
    end else if (line_tick && chan_start) begin
      idle_seen_q <= chan_ctrl.channel_idle_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      line_bit_q             <= 1'b1;
      line_valid_q           <= 1'b0;
      egress_channel_clock_q <= 1'b0;
    end else begin
      line_bit_q   <= line_tick ? out_bit : line_bit_q;
      line_valid_q <= line_tick;
      // Gapping follows the per-channel idle bit only, never the trunk bit
      egress_channel_clock_q <= line_tick && !fbit_slot && !(fractional_mode &&
        (chan_start ? chan_ctrl.channel_idle_enable : idle_seen_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (@(posedge clk) disable iff (!reset_n)
    s_bus_req |=> s_answer)
    else $error("bus answer not given after one wait cycle");

  a_trunk_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (trunk && !sig_frame && !yellow && chan_ctrl.idle_code != 8'h00)
      |-> after_yel == chan_ctrl.idle_code)
    else $error("trunk conditioning did not substitute idle code");

  a_eclk_trunk: assert property (@(posedge clk) disable iff (!reset_n)
    (line_tick && chan_start && !fbit_slot && !chan_ctrl.channel_idle_enable)
      |=> egress_channel_clock_q)
    else $error("channel clock gated without per-channel idle");

  a_sig_upper: assert property (@(posedge clk) disable iff (!reset_n)
    (!chan_ctrl.signaling_control_upper) |-> after_sig[0] == after_idle[0])
    else $error("signaling conditioned without upper control bit");

  a_zcs_bit7: assert property (@(posedge clk) disable iff (!reset_n)
    (line_tick && chan_start && !ib_en && after_yel == 8'h00 && zcs_eff == T1XF_ZCS_BIT7)
      |=> !line_bit_q && shift_q == 8'h04)
    else $error("bit 7 not forced on zero byte");

  a_zcs_bit8: assert property (@(posedge clk) disable iff (!reset_n)
    (after_yel == 8'h00 && zcs_eff == T1XF_ZCS_BIT8 && !sig_frame) |-> shaped == 8'h01)
    else $error("bit 8 not forced on zero byte");

  a_yel_sf: assert property (@(posedge clk) disable iff (!reset_n)
    (yellow && !esf && after_sig != 8'h00) |-> !shaped[6])
    else $error("bit 2 not cleared under yellow alarm");

  a_ib_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (ib_use && ib_idx_q == ib_last) |=> ib_idx_q == 3'h0)
    else $error("inband code did not wrap at selected length");

  a_ib_payload: assert property (@(posedge clk) disable iff (!reset_n)
    (line_tick && ib_en && !fbit_slot) |=> line_bit_q == $past(ib_bit))
    else $error("inband bit not placed in payload");

  a_uf_frame: assert property (@(posedge clk) disable iff (!reset_n)
    (line_tick && fbit_slot && ib_uf && !ib_en) |=> line_bit_q)
    else $error("framing inserted while unframed");

endmodule
`default_nettype wire

/* hdl/t1xf_pkg.sv */
package t1xf_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [7:0]  T1XF_IDX_BASIC_CFG   = 8'h44;
  localparam logic [7:0]  T1XF_IDX_ALARM_CTRL  = 8'h45;
  localparam logic [7:0]  T1XF_IDX_INBAND_CTRL = 8'h46;
  localparam logic [7:0]  T1XF_IDX_INBAND_PAT  = 8'h47;
  localparam logic [7:0]  T1XF_IDX_STATUS      = 8'h48;
  // Field positions
  localparam int          T1XF_CFG_TRUNK_BIT   = 7;
  localparam int          T1XF_CFG_ESF_BIT     = 4;
  localparam int          T1XF_ALM_YEL_BIT     = 1;
  localparam int          T1XF_IBC_EN_BIT      = 7;
  localparam int          T1XF_IBC_UF_BIT      = 6;
  localparam logic [7:0]  T1XF_ALM_MASK        = 8'h03;
  localparam logic [7:0]  T1XF_IBC_MASK        = 8'hc3;
  // Reset values
  localparam logic [7:0]  T1XF_RST_CFG         = 8'h00;
  localparam logic [7:0]  T1XF_RST_ALM         = 8'h00;
  localparam logic [7:0]  T1XF_RST_IBC         = 8'h00;
  // Frame geometry
  localparam logic [7:0]  T1XF_FRAME_BITS      = 8'hc1;
  localparam logic [4:0]  T1XF_SF_FRAMES       = 5'h0c;
  localparam logic [4:0]  T1XF_ESF_FRAMES      = 5'h18;
  localparam logic [11:0] T1XF_SF_FBITS        = 12'h8dc;
  localparam logic [5:0]  T1XF_ESF_FAS         = 6'h0b;
  localparam logic [5:0]  T1XF_CRC_POLY        = 6'h03;
  localparam logic [16:0] T1XF_YEL_BOC         = 17'h1ff00;
  localparam logic [4:0]  T1XF_YEL_BOC_LEN     = 5'h11;
  // Zero code suppression codes, and the shortest inband code length
  localparam logic [1:0]  T1XF_ZCS_NONE        = 2'h0;
  localparam logic [1:0]  T1XF_ZCS_BIT8        = 2'h1;
  localparam logic [1:0]  T1XF_ZCS_BIT7        = 2'h3;
  localparam logic [2:0]  T1XF_CODE_LEN_MIN    = 3'h5;

  typedef struct packed {
    logic [7:0] payload;
    logic [7:0] idle_code;
    logic       channel_idle_enable;
    logic       channel_signaling_condition;
    logic       signaling_control_upper;
    logic       signaling_bit;
    logic [1:0] zero_suppress_select;
  } t1xf_chan_t;
endpackage

/* tb/t1xf_line_model.sv */
`timescale 1ns/10ps
`default_nettype none
module t1xf_line_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] gap,
  output logic            line_tick
);
  logic [3:0] cnt_q;

  // Line side paces the bits; a wider gap stands for a slow line, zero for back to back
  always_ff @(posedge clk) begin
    if (!reset_n || cnt_q >= gap) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    line_tick <= reset_n && (cnt_q >= gap);
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import t1xf_pkg::*;
  logic        clk     = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] adr     = 12'h000;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [3:0]  be      = 4'hf;
  logic [31:0] wd      = 32'h0;
  logic        frac    = 1'b0;
  logic [3:0]  gap     = 4'h3;
  t1xf_chan_t  cc      = '0;
  logic [31:0] rdat;
  logic        wait_r;
  logic        tick;
  logic [4:0]  chan;
  logic        lbit;
  logic        lval;
  logic        eclk;
  logic [7:0]  rv;
  logic [7:0]  pat;
  logic [7:0]  pay;
  logic        bitq[$];
  logic        seq[$];
  int          pos;
  int          eclks;
  int          e0;
  int          s;
  int          miscompares;
  int          total_checks;
  logic [1:0]  zg[7] = '{2'h0, 2'h1, 2'h3, 2'h0, 2'h1, 2'h3, 2'h0};
  logic [1:0]  zc[7] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h1, 2'h0, 2'h0};

  t1xf_framer u_t1xf_framer (.clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wait_r), .line_tick(tick), .fractional_mode(frac), .chan_ctrl(cc),
    .chan_index_q(chan), .line_bit_q(lbit), .line_valid_q(lval), .egress_channel_clock_q(eclk));
  t1xf_line_model u_t1xf_line_model (.clk(clk), .reset_n(reset_n), .gap(gap), .line_tick(tick));

  always #2 clk = ~clk;

  // Line capture; a reset restarts the bit count with the framer's own frame count
  always @(posedge clk) begin
    if (!reset_n) begin
      pos <= 0;
      bitq.delete();
    end else if (lval) begin
      bitq.push_back(lbit);
      chk("channel index", (pos % 193 == 0) ? 0 : (pos % 193 - 1) / 8, chan);
      pos <= pos + 1;
    end
    if (eclk) begin
      eclks <= eclks + 1;
    end
  end

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    $display("timeout");
    stop_test();
  end

  ////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wait_r !== 1'b0) @(posedge clk);
    rv = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("register", {24'h0, e}, rdat);
  endtask

  // Waits for n whole frames that start after the current one
  task automatic grab(input int n);
    s = (pos / 193 + 1) * 193;
    while (pos < s + n * 193) @(posedge clk);
  endtask

  task automatic fas_chk(input int n);
    for (int f = 0; f < n; f++) begin
      if ((s / 193 + f) % 4 == 3) begin
        chk("fas bit", T1XF_ESF_FAS[5 - ((s / 193 + f) % 24) / 4], bitq[s + f * 193]);
      end
    end
  endtask

  function automatic logic [7:0] byte_at(int f, int ch);
    logic [7:0] b;
    for (int k = 0; k < 8; k++) b[7 - k] = bitq[s + f * 193 + 1 + ch * 8 + k];
    return b;
  endfunction

  // Yellow first, then suppression, so a byte emptied by the alarm is still padded
  function automatic logic [7:0] shape(logic [7:0] p, logic [1:0] z, logic sig, logic yel);
    logic [7:0] b;
    b = p;
    if (yel) b[6] = 1'b0;
    if (b == 8'h00 && (z == 2'h3 || (z == 2'h1 && sig))) b = 8'h02;
    else if (b == 8'h00 && z == 2'h1) b = 8'h01;
    return b;
  endfunction

  function automatic logic cyc(logic [16:0] v, int top, int len);
    logic ok;
    for (int p = 0; p < len; p++) begin
      ok = 1'b1;
      foreach (seq[i]) if (seq[i] !== v[top - (i + p) % len]) ok = 1'b0;
      if (ok) return 1'b1;
    end
    return 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(59));
    pay = 8'(($urandom() | 32'h10) & 32'hfe);
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(12'h110, T1XF_RST_CFG);
    rdchk(12'h114, T1XF_RST_ALM);
    rdchk(12'h118, T1XF_RST_IBC);
    be <= 4'he;
    bus(1'b1, 12'h110, 8'h93);
    be <= 4'hf;
    rdchk(12'h110, 8'h00);
    rdchk(12'h200, 8'h00);
    bus(1'b1, 12'h114, 8'h02);
    rdchk(12'h114, 8'h02);
    bus(1'b1, 12'h114, 8'h00);
    $display("register test done");
    gap <= 4'h1;
    grab(12);
    for (int f = 0; f < 12; f++) begin
      chk("sf frame bit", T1XF_SF_FBITS[11 - (s / 193 + f) % 12], bitq[s + f * 193]);
    end
    $display("superframe test done");
    for (int i = 0; i < 7; i++) begin
      cc.zero_suppress_select <= zc[i];
      cc.payload <= (i > 4) ? pay : 8'h00;
      bus(1'b1, 12'h110, {6'h0, zg[i]});
      bus(1'b1, 12'h114, {6'h0, i == 6, 1'b0});
      grab(6);
      for (int f = 0; f < 6; f++) begin
        chk("chan byte", shape(cc.payload, zg[i] | zc[i], (s / 193 + f) % 6 == 5, i == 6), byte_at(f, f * 3));
      end
      $display("channel byte case %0d done", i);
    end
    bus(1'b1, 12'h114, 8'h00);
    cc.zero_suppress_select <= 2'h0;
    cc.idle_code <= pay;
    cc.signaling_control_upper <= 1'b1;
    frac <= 1'b1;
    bus(1'b1, 12'h110, 8'h80);
    grab(4);
    for (int f = 0; f < 4; f++) begin
      if ((s / 193 + f) % 6 != 5) chk("trunk byte", pay, byte_at(f, 23 - f));
    end
    e0 = eclks;
    repeat (772) @(posedge clk);
    chk("clock pulses", 384, eclks - e0);
    bus(1'b1, 12'h110, 8'h00);
    cc.channel_idle_enable <= 1'b1;
    // Let the channel in flight finish before counting
    repeat (24) @(posedge clk);
    e0 = eclks;
    repeat (772) @(posedge clk);
    chk("idle clock pulses", 0, eclks - e0);
    frac <= 1'b0;
    cc.channel_idle_enable <= 1'b0;
    $display("trunk test done");
    pat = 8'($urandom());
    bus(1'b1, 12'h11c, pat);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rdchk(12'h11c, pat);
    rdchk(12'h110, 8'h00);
    $display("reset test done");
    gap <= 4'h0;
    bus(1'b1, 12'h110, 8'h10);
    grab(24);
    fas_chk(24);
    bus(1'b1, 12'h114, 8'h02);
    grab(72);
    seq.delete();
    // Data link slots sit in even frames of the superframe
    for (int f = (s / 193) % 2; f < 72; f += 2) seq.push_back(bitq[s + f * 193]);
    chk("yellow code", 1, cyc(T1XF_YEL_BOC, 16, 17));
    $display("extended superframe test done");
    for (int l = 0; l < 4; l++) begin
      pat = (l == 1) ? 8'h6c : 8'($urandom());
      bus(1'b1, 12'h11c, pat);
      bus(1'b1, 12'h118, {6'h20, l[1:0]});
      bus(1'b0, 12'h120, 8'h00);
      chk("status enable", 1, rv[7]);
      chk("status frame", 1, rv[4:0] < 5'h18);
      grab(4);
      seq.delete();
      for (int i = 0; i < 772; i++) if (i % 193 != 0) seq.push_back(bitq[s + i]);
      chk("framed code", 1, cyc({9'h0, pat}, 7, l + 5));
      fas_chk(4);
      bus(1'b1, 12'h118, {6'h30, l[1:0]});
      grab(2);
      seq.delete();
      for (int i = 0; i < 386; i++) seq.push_back(bitq[s + i]);
      chk("unframed code", 1, cyc({9'h0, pat}, 7, l + 5));
      bus(1'b1, 12'h118, 8'h00);
    end
    grab(1);
    chk("code stopped", shape(pay, 2'h0, (s / 193) % 6 == 5, 1'b0), byte_at(0, 9));
    bus(1'b1, 12'h118, 8'h40);
    grab(2);
    chk("framing slot", 1, bitq[s]);
    chk("framing slot", 1, bitq[s + 193]);
    bus(1'b1, 12'h118, 8'h00);
    $display("inband test done");
    stop_test();
  end
endmodule
`default_nettype wire
